// file: hw/dsx1_port_ctrl.sv
// DSX-1 tributary port control: enable, framing, coding, failure ones, alarms
//
// Notes on behaviour
// RULE_01 - Disabled port neither sends nor receives data
// RULE_02 - Disabling the port clears all cross-connects
// RULE_03 - Disabled port raises no alarms, indicators off
// RULE_04 - One framing choice, D4 or ESF; ESF default
// RULE_05 - Line code AMI or B8ZS; B8ZS default
// RULE_06 - Failure with substitution on sends all ones
// RULE_07 - Substitution off passes received data unchanged
// RULE_08 - Loss-of-signal event only while enabled
// RULE_09 - Out-of-frame event only while enabled
// RULE_10 - Alarm-indication event only while enabled
// RULE_11 - Yellow alarm event only while enabled
// RULE_12 - Detect conditions with customary T1 criteria
//
// The register offsets and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module dsx1_port_ctrl #(
    parameter int CONT_OOF_CYCLES = dsx1_port_pkg::CONT_OOF_CYC
) (
    input  wire logic        SYS_CLK,
    input  wire logic        RST_N,
    input  wire logic [3:0]  AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    input  wire logic [3:0]  AVS_BYTEENABLE,
    output logic      [31:0] AVS_READDATA,
    output logic             AVS_WAITREQUEST,
    input  wire logic        LINE_BIT,
    input  wire logic        LINE_BIT_VALID,
    input  wire logic        FBIT_VALID,
    input  wire logic        FBIT_ERR,
    input  wire logic        REFRAMED,
    input  wire logic        FDL_BIT,
    input  wire logic        FDL_VALID,
    input  wire logic [7:0]  RX_DATA,
    input  wire logic [4:0]  RX_SLOT,
    input  wire logic        RX_VALID,
    output logic             RX_READY,
    output logic      [7:0]  NET_DATA,
    output logic      [4:0]  NET_SLOT,
    output logic             NET_VALID,
    input  wire logic        NET_READY,
    output logic             LINE_TX_ENABLE,
    output logic             LINE_FRAMING_ESF,
    output logic             LINE_CODE_B8ZS,
    output logic      [3:0]  ALARM_EVT,
    output logic             LED_PORT_ON,
    output logic             LED_ALARM
);
    localparam int COOF_W = $clog2(CONT_OOF_CYCLES + 1);
    localparam int BUF_W  = 8 + dsx1_port_pkg::SLOT_W;

    ////////////////////////////////////////////////////////////////////////////////
    // Parameter check
    if (CONT_OOF_CYCLES < 1)
    begin : g_bad
        $error("dsx1_port_ctrl: CONT_OOF_CYCLES must be at least 1");
    end

    typedef struct packed {
        dsx1_port_pkg::port_st_t st;
        logic [7:0]              ctrl;
        logic [23:0]             xcon;
        logic [3:0]              evt;
        logic [3:0]              evt_pulse;
        logic [3:0]              cond;
        logic                    coof;
        logic [COOF_W-1:0]       coof_cnt;
        logic                    ack;
        logic [31:0]             rdata;
        logic [7:0]              los_cnt;
        logic [10:0]             ais_bits;
        logic [1:0]              ais_zeros;
        logic [4:0]              ferr_hist;
        logic [7:0]              yd4_cnt;
        logic [15:0]             fdl_sh;
        logic [5:0]              yesf_gap;
    } state_t;

    localparam state_t S_RST = '{
        st:   dsx1_port_pkg::ST_OFF,
        ctrl: dsx1_port_pkg::CTRL_RST,
        xcon: dsx1_port_pkg::XCON_RST,
        default: '0
    };

    state_t     s_q;
    state_t     s_d;
    logic       on;
    logic       fail;
    logic       subst;
    logic       fwd;
    logic       buf_in_ready;
    logic       rx_take;
    logic [7:0] rx_byte;

    ////////////////////////////////////////////////////////////////////////////////
    // Decoding used by the data path to pick out mapped slots
    function automatic logic slot_mapped(input logic [23:0] map, input logic [4:0] slot);
        slot_mapped = (slot < 5'(dsx1_port_pkg::SLOTS)) ? map[slot] : 1'b0;
    endfunction

    // Merge write data into a register under the byte enables
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
        merge = old;
        for (int i = 0; i < 4; i++)
            if (be[i])
                merge[8*i +: 8] = wd[8*i +: 8];
    endfunction

    // Count the F-bit errors that fall inside the window
    function automatic logic [2:0] count_errs(input logic [4:0] hist, input logic [4:0] mask);
        count_errs = '0;
        for (int i = 0; i < 5; i++)
            count_errs = count_errs + 3'(hist[i] & mask[i]);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Data path: mapped slots go through the buffer, others are drained
    assign on      = (s_q.st == dsx1_port_pkg::ST_ON);
    assign fail    = s_q.cond[dsx1_port_pkg::CI_LOS] | s_q.cond[dsx1_port_pkg::CI_AIS] | s_q.coof;
    assign subst   = s_q.ctrl[dsx1_port_pkg::CB_FONES] & fail;
    assign fwd     = on & slot_mapped(s_q.xcon, RX_SLOT);     // RULE_01
    assign rx_byte = subst ? dsx1_port_pkg::ALL_ONES : RX_DATA; // RULE_06 RULE_07
    // Unmapped bytes are consumed so a stalled network side blocks only mapped slots
    assign RX_READY = ~fwd | buf_in_ready;
    assign rx_take  = RX_VALID & RX_READY;

    two_entry_buffer #(
        .WIDTH (BUF_W),
        .DEPTH (2)
    ) u_buf (
        .clk       (SYS_CLK),
        .rst_n     (RST_N),
        .flush     (~on),
        .in_valid  (RX_VALID & fwd),
        .in_ready  (buf_in_ready),
        .in_data   ({RX_SLOT, rx_byte}),
        .out_valid (NET_VALID),
        .out_ready (NET_READY),
        .out_data  ({NET_SLOT, NET_DATA})
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Bus answer and line configuration from flip-flops, except waitrequest which also uses the request
    assign AVS_WAITREQUEST  = (AVS_READ | AVS_WRITE) & ~s_q.ack;
    assign AVS_READDATA     = s_q.rdata;
    assign LINE_TX_ENABLE   = on;                                        // RULE_01
    assign LINE_FRAMING_ESF = s_q.ctrl[dsx1_port_pkg::CB_ESF];           // RULE_04
    assign LINE_CODE_B8ZS   = s_q.ctrl[dsx1_port_pkg::CB_B8ZS];          // RULE_05
    assign ALARM_EVT        = s_q.evt_pulse;
    assign LED_PORT_ON      = on;                                        // RULE_03
    assign LED_ALARM        = on & (|s_q.cond);                          // RULE_03

    ////////////////////////////////////////////////////////////////////////////////
    // Next state of the whole block
    always_comb
    begin
        logic [31:0] wd;
        logic [3:0]  rise;
        logic [3:0]  enables;
        logic [3:0]  clr;
        logic [4:0]  hist;
        logic [4:0]  mask;
        logic [1:0]  zeros;
        logic [15:0] sh;
        s_d       = s_q;
        wd        = '0;
        clr       = '0;
        hist      = '0;
        mask      = '0;
        zeros     = '0;
        sh        = '0;
        rise      = '0;
        enables   = '0;
        s_d.ack   = 1'b0;
        // Register access: one wait cycle, read data captured at request
        if ((AVS_READ | AVS_WRITE) & ~s_q.ack)
        begin
            s_d.ack   = 1'b1;
            s_d.rdata = '0;
            case (AVS_ADDRESS)
                dsx1_port_pkg::OFS_CTRL: s_d.rdata[7:0] = s_q.ctrl;
                dsx1_port_pkg::OFS_STAT: s_d.rdata[6:0] = {on, fail, s_q.coof, s_q.cond};
                dsx1_port_pkg::OFS_EVT:  s_d.rdata[3:0] = s_q.evt;
                dsx1_port_pkg::OFS_XCON: s_d.rdata[23:0] = s_q.xcon;
                default:                 s_d.rdata = '0;
            endcase
        end
        if (AVS_WRITE & s_q.ack)
        begin
            case (AVS_ADDRESS)
                dsx1_port_pkg::OFS_CTRL:
                begin
                    wd         = merge({24'h000000, s_q.ctrl}, AVS_WRITEDATA, AVS_BYTEENABLE);
                    s_d.ctrl   = wd[7:0];
                end
                dsx1_port_pkg::OFS_EVT:  clr = AVS_BYTEENABLE[0] ? AVS_WRITEDATA[3:0] : 4'h0;
                // A disabled port carries no cross-connects
                dsx1_port_pkg::OFS_XCON:
                    if (on)
                    begin
                        wd       = merge({8'h00, s_q.xcon}, AVS_WRITEDATA, AVS_BYTEENABLE);
                        s_d.xcon = wd[23:0];
                    end
                default: ;
            endcase
        end
        // Port state; leaving the on state wipes the map
        case (s_q.st)
            dsx1_port_pkg::ST_OFF:
                if (s_q.ctrl[dsx1_port_pkg::CB_EN])
                    s_d.st = dsx1_port_pkg::ST_ON;
            dsx1_port_pkg::ST_ON:
                if (!s_q.ctrl[dsx1_port_pkg::CB_EN])
                begin
                    s_d.st   = dsx1_port_pkg::ST_OFF;
                    s_d.xcon = dsx1_port_pkg::XCON_RST;                  // RULE_02
                end
            default: s_d.st = dsx1_port_pkg::ST_OFF;
        endcase
        // Loss of signal: a run of zeros, cleared by the next one
        if (LINE_BIT_VALID)
        begin
            if (LINE_BIT)
            begin
                s_d.los_cnt                       = '0;
                s_d.cond[dsx1_port_pkg::CI_LOS]   = 1'b0;
            end
            else if (s_q.los_cnt != dsx1_port_pkg::LOS_ZEROS)
            begin
                s_d.los_cnt = s_q.los_cnt + 8'h01;
                if (s_d.los_cnt == dsx1_port_pkg::LOS_ZEROS)
                    s_d.cond[dsx1_port_pkg::CI_LOS] = 1'b1;              // RULE_12
            end
            // Alarm indication: too few zeros in a fixed window of line bits
            zeros = s_q.ais_zeros;
            if (!LINE_BIT && zeros != dsx1_port_pkg::AIS_MAX_ZERO)
                zeros = zeros + 2'h1;
            s_d.ais_zeros = zeros;
            s_d.ais_bits  = s_q.ais_bits + 11'h001;
            if (s_q.ais_bits == dsx1_port_pkg::AIS_WIN_LAST)
            begin
                s_d.cond[dsx1_port_pkg::CI_AIS] = (zeros < dsx1_port_pkg::AIS_MAX_ZERO); // RULE_12
                s_d.ais_zeros = '0;
            end
        end
        // Out of frame: two F-bit errors in the window of the chosen format
        mask = s_q.ctrl[dsx1_port_pkg::CB_ESF] ? dsx1_port_pkg::OOF_MASK_ESF
                                               : dsx1_port_pkg::OOF_MASK_D4; // RULE_04
        if (FBIT_VALID)
        begin
            hist          = {s_q.ferr_hist[3:0], FBIT_ERR};
            s_d.ferr_hist = hist;
            if (count_errs(hist, mask) >= dsx1_port_pkg::OOF_ERRS)
                s_d.cond[dsx1_port_pkg::CI_OOF] = 1'b1;                  // RULE_12
        end
        if (REFRAMED)
        begin
            s_d.ferr_hist                   = '0;
            s_d.cond[dsx1_port_pkg::CI_OOF] = 1'b0;
        end
        // Continuous frame loss counts toward failure after a long hold
        if (s_q.cond[dsx1_port_pkg::CI_OOF])
        begin
            if (s_q.coof_cnt != COOF_W'(CONT_OOF_CYCLES))
                s_d.coof_cnt = s_q.coof_cnt + COOF_W'(1);
            else
                s_d.coof = 1'b1;
        end
        else
        begin
            s_d.coof_cnt = '0;
            s_d.coof     = 1'b0;
        end
        // Yellow: bit 2 low in every channel (D4) or pattern on the data link (ESF)
        if (!s_q.ctrl[dsx1_port_pkg::CB_ESF] && rx_take)
        begin
            if (RX_DATA[dsx1_port_pkg::YEL_D4_BIT])
            begin
                s_d.yd4_cnt                     = '0;
                s_d.cond[dsx1_port_pkg::CI_YEL] = 1'b0;
            end
            else if (s_q.yd4_cnt != dsx1_port_pkg::YEL_D4_BYTES)
            begin
                s_d.yd4_cnt = s_q.yd4_cnt + 8'h01;
                if (s_d.yd4_cnt == dsx1_port_pkg::YEL_D4_BYTES)
                    s_d.cond[dsx1_port_pkg::CI_YEL] = 1'b1;              // RULE_12
            end
        end
        else if (s_q.ctrl[dsx1_port_pkg::CB_ESF] && FDL_VALID)
        begin
            sh         = {s_q.fdl_sh[14:0], FDL_BIT};
            s_d.fdl_sh = sh;
            if (sh == dsx1_port_pkg::YEL_ESF_PAT)
            begin
                s_d.yesf_gap                    = '0;
                s_d.cond[dsx1_port_pkg::CI_YEL] = 1'b1;                  // RULE_12
            end
            else if (s_q.yesf_gap != dsx1_port_pkg::YEL_ESF_GAP)
                s_d.yesf_gap = s_q.yesf_gap + 6'h01;
            else
                s_d.cond[dsx1_port_pkg::CI_YEL] = 1'b0;
        end
        // A disabled port keeps every detector at rest
        if (!on)
        begin
            s_d.cond      = '0;                                          // RULE_03
            s_d.coof      = 1'b0;
            s_d.coof_cnt  = '0;
            s_d.los_cnt   = '0;
            s_d.ais_bits  = '0;
            s_d.ais_zeros = '0;
            s_d.ferr_hist = '0;
            s_d.yd4_cnt   = '0;
            s_d.fdl_sh    = '0;
            s_d.yesf_gap  = '0;
        end
        // Events on a rising condition, gated by each enable; set beats clear
        enables[dsx1_port_pkg::CI_LOS] = s_q.ctrl[dsx1_port_pkg::CB_LOSE]; // RULE_08
        enables[dsx1_port_pkg::CI_OOF] = s_q.ctrl[dsx1_port_pkg::CB_OOFE]; // RULE_09
        enables[dsx1_port_pkg::CI_AIS] = s_q.ctrl[dsx1_port_pkg::CB_AISE]; // RULE_10
        enables[dsx1_port_pkg::CI_YEL] = s_q.ctrl[dsx1_port_pkg::CB_YELE]; // RULE_11
        rise          = s_d.cond & ~s_q.cond;
        s_d.evt_pulse = rise & enables & {4{on}};                         // RULE_03
        s_d.evt       = (s_q.evt & ~clr) | s_d.evt_pulse;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
            s_q <= S_RST;
        else
            s_q <= s_d;
    end

endmodule

// file: hw/dsx1_port_pkg.sv
// Shared constants for the DSX-1 tributary port control block
package dsx1_port_pkg;

    // Clock and timing
    localparam int CLK_HZ        = 100_000_000;
    localparam int CONT_OOF_MS   = 2500;                          // Time a frame loss must last
    localparam int CONT_OOF_CYC  = CONT_OOF_MS * (CLK_HZ / 1000);

    // Register byte offsets
    localparam int         ADDR_W   = 4;
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_STAT = 4'h4;
    localparam logic [3:0] OFS_EVT  = 4'h8;
    localparam logic [3:0] OFS_XCON = 4'hc;

    // Control register fields and reset value
    localparam int         CTRL_W   = 8;
    localparam int         CB_EN    = 0;
    localparam int         CB_ESF   = 1;
    localparam int         CB_B8ZS  = 2;
    localparam int         CB_FONES = 3;
    localparam int         CB_LOSE  = 4;
    localparam int         CB_OOFE  = 5;
    localparam int         CB_AISE  = 6;
    localparam int         CB_YELE  = 7;
    localparam logic [7:0] CTRL_RST = 8'hfe;

    // Condition index, shared by status, event and enable bits
    localparam int NCOND  = 4;
    localparam int CI_LOS = 0;
    localparam int CI_OOF = 1;
    localparam int CI_AIS = 2;
    localparam int CI_YEL = 3;

    // Status register fields above the conditions
    localparam int SB_COOF = 4;
    localparam int SB_FAIL = 5;
    localparam int SB_ON   = 6;

    // Cross-connect map
    localparam int          SLOTS    = 24;
    localparam int          SLOT_W   = 5;
    localparam logic [23:0] XCON_RST = 24'h000000;

    // Detection criteria
    localparam logic [7:0]  LOS_ZEROS    = 8'haf;   // 175 zero bits in a row
    localparam logic [10:0] AIS_WIN_LAST = 11'h7ff; // Window of 2048 bits
    localparam logic [1:0]  AIS_MAX_ZERO = 2'h3;    // Fewer zeros than this is all ones
    localparam logic [2:0]  OOF_ERRS     = 3'h2;
    localparam logic [4:0]  OOF_MASK_D4  = 5'h1f;   // Two errors out of five F bits
    localparam logic [4:0]  OOF_MASK_ESF = 5'h0f;   // Two errors out of four F bits
    localparam logic [7:0]  YEL_D4_BYTES = 8'hff;   // 255 channels with bit 2 at zero
    localparam int          YEL_D4_BIT   = 6;       // Bit 2 of a channel, sent msb first
    localparam logic [15:0] YEL_ESF_PAT  = 16'hff00;
    localparam logic [5:0]  YEL_ESF_GAP  = 6'h20;   // Data link bits without the pattern
    localparam logic [7:0]  ALL_ONES     = 8'hff;

    // Port state, one-hot
    typedef enum logic [1:0] {
        ST_OFF = 2'b01,
        ST_ON  = 2'b10
    } port_st_t;

endpackage

// file: hw/two_entry_buffer.sv
// Small FIFO that holds words between the line receiver and the network side
`timescale 1ns/1ps
module two_entry_buffer #(
    parameter int WIDTH = 13,
    parameter int DEPTH = 2
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             flush,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    ////////////////////////////////////////////////////////////////////////////////
    // Pointer arithmetic needs a power of two
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
    begin : g_bad
        $error("two_entry_buffer: DEPTH must be a power of two of at least 2");
    end

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wr;
        logic [AW-1:0]               rd;
        logic [AW:0]                 cnt;
    } buf_t;

    buf_t s_q;
    buf_t s_d;
    logic push;
    logic pop;

    ////////////////////////////////////////////////////////////////////////////////
    // Honest full and empty straight from the count
    assign in_ready  = (s_q.cnt != (AW+1)'(DEPTH));
    assign out_valid = (s_q.cnt != '0);
    assign out_data  = s_q.mem[s_q.rd];   // Storage is flip-flops, so data is registered
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // Next state; a flush drops whatever is held
    always_comb
    begin
        s_d = s_q;
        if (push)
        begin
            s_d.mem[s_q.wr] = in_data;
            s_d.wr          = s_q.wr + AW'(1);
        end
        if (pop)
            s_d.rd = s_q.rd + AW'(1);
        s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
        if (flush)
        begin
            s_d.wr  = '0;
            s_d.rd  = '0;
            s_d.cnt = '0;
        end
    end

    // State register
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            s_q <= '0;
        else
            s_q <= s_d;
    end

endmodule

// file: bench/dsx1_port_ctrl_asserts.sv
// Port-level checks on the tributary port control block
`timescale 1ns/1ps
module dsx1_port_ctrl_asserts (
    input wire logic       SYS_CLK,
    input wire logic       RST_N,
    input wire logic       AVS_READ,
    input wire logic       AVS_WRITE,
    input wire logic       AVS_WAITREQUEST,
    input wire logic       LINE_BIT,
    input wire logic       LINE_BIT_VALID,
    input wire logic       FBIT_VALID,
    input wire logic       FBIT_ERR,
    input wire logic       FDL_VALID,
    input wire logic       RX_VALID,
    input wire logic       RX_READY,
    input wire logic [7:0] NET_DATA,
    input wire logic [4:0] NET_SLOT,
    input wire logic       NET_VALID,
    input wire logic       NET_READY,
    input wire logic       LINE_TX_ENABLE,
    input wire logic [3:0] ALARM_EVT,
    input wire logic       LED_PORT_ON,
    input wire logic       LED_ALARM
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);

    ////////////////////////////////////////////////////////////////////////////
    // Bus answers after one wait cycle; a stalled word never changes while the port is on
    bus_wait_a: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST
        |=> !AVS_WAITREQUEST) else $error("bus wait not one cycle");
    net_hold_a: assert property (NET_VALID && !NET_READY && LINE_TX_ENABLE && !AVS_WRITE
        |=> NET_VALID && $stable(NET_DATA) && $stable(NET_SLOT)) else $error("word lost");
    rx_refuse_a: assert property (!RX_READY |-> NET_VALID)
        else $error("refused with room");

    ////////////////////////////////////////////////////////////////////////////
    // A disabled port stays silent; each event follows its own strobe
    off_quiet_a: assert property (!LINE_TX_ENABLE && $past(!LINE_TX_ENABLE)
        |-> ALARM_EVT == 4'h0 && !LED_ALARM && !LED_PORT_ON) else $error("alarm while off");
    los_cause_a: assert property (ALARM_EVT[0] |-> $past(LINE_BIT_VALID && !LINE_BIT))
        else $error("loss event without zero");
    oof_cause_a: assert property (ALARM_EVT[1] |-> $past(FBIT_VALID && FBIT_ERR))
        else $error("frame event without error");
    ais_cause_a: assert property (ALARM_EVT[2] |-> $past(LINE_BIT_VALID))
        else $error("indication event without bit");
    yel_cause_a: assert property (ALARM_EVT[3] |-> $past(RX_VALID && RX_READY || FDL_VALID))
        else $error("yellow event without input");

    cover property (ALARM_EVT[0]);
    cover property (NET_VALID && NET_READY);
    cover property (!RX_READY);
endmodule

bind dsx1_port_ctrl dsx1_port_ctrl_asserts i_dsx1_port_ctrl_asserts (.SYS_CLK, .RST_N,
    .AVS_READ, .AVS_WRITE, .AVS_WAITREQUEST, .LINE_BIT, .LINE_BIT_VALID, .FBIT_VALID,
    .FBIT_ERR, .FDL_VALID, .RX_VALID, .RX_READY, .NET_DATA, .NET_SLOT, .NET_VALID,
    .NET_READY, .LINE_TX_ENABLE, .ALARM_EVT, .LED_PORT_ON, .LED_ALARM);

// file: bench/dsx1_line_model.sv
// Terminal equipment on the tributary line: bit stream, F bits, DS0 bytes
`timescale 1ns/1ps
module dsx1_line_model (
    input  wire logic       clk,
    output logic            line_bit,
    output logic            line_valid,
    output logic            fbit_valid,
    output logic            fbit_err,
    output logic            reframed,
    output logic            fdl_bit,
    output logic            fdl_valid,
    output logic      [7:0] rx_data,
    output logic      [4:0] rx_slot,
    output logic            rx_valid,
    input  wire logic       rx_ready
);
    // Idle slot is out of range so a stale byte can never look mapped
    initial
    begin
        {line_bit, line_valid, fbit_valid, fbit_err, reframed, fdl_bit, fdl_valid} = '0;
        {rx_data, rx_slot, rx_valid} = {8'ha5, 5'h1f, 1'b0};
    end

    // Bits strobed every cycle
    task automatic send_bits(input logic v, input int cnt);
        repeat (cnt)
        begin
            @(posedge clk);
            line_bit   <= v;
            line_valid <= 1'b1;
        end
        @(posedge clk);
        line_valid <= 1'b0;
        line_bit   <= ~v;
    endtask

    task automatic send_fbit(input logic e);
        @(posedge clk);
        fbit_valid <= 1'b1;
        fbit_err   <= e;
        @(posedge clk);
        fbit_valid <= 1'b0;
        fbit_err   <= ~e;
    endtask

    // Byte held until ready is seen high at an edge
    task automatic send_byte(input logic [4:0] s, input logic [7:0] d, output logic ok);
        int   n;
        logic r;
        n = 0;
        @(posedge clk);
        {rx_slot, rx_data, rx_valid} <= {s, d, 1'b1};
        do
        begin
            @(posedge clk);
            r = rx_ready;
            n++;
        end
        while (r !== 1'b1 && n < 40);
        ok = (r === 1'b1);
        {rx_slot, rx_data, rx_valid} <= {5'h1f, ~d, 1'b0};
    endtask
endmodule

// file: bench/tb.sv
// Self-checking bench for the tributary port control block
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_total++; \
    $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module tb;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [3:0]  adr = 4'h0;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic        netr = 1'b1;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdo, rdat;
    logic        wreq, lb, lv, fv, fe, rf, db, dv, rxv, rxr, netv, ok;
    logic        txen, esf, b8, ledon, ledal;
    logic [7:0]  rxd, netd;
    logic [4:0]  rxs, nets;
    logic [3:0]  evt;
    logic [7:0]  got[$];
    logic [7:0]  exp_q[6] = '{8'h5a, 8'hff, 8'h3c, 8'h11, 8'h22, 8'h33};
    int          err_total = 0;
    int          n_tests = 0;

    always #5 clk = ~clk;

    // Delivered network words, kept for comparison
    always @(posedge clk)
        if (netv === 1'b1 && netr === 1'b1)
            got.push_back(netd);

    dsx1_port_ctrl #(.CONT_OOF_CYCLES(20)) i_dsx1_port_ctrl (.SYS_CLK(clk), .RST_N(rst_n),
        .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdat),
        .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdo), .AVS_WAITREQUEST(wreq), .LINE_BIT(lb),
        .LINE_BIT_VALID(lv), .FBIT_VALID(fv), .FBIT_ERR(fe), .REFRAMED(rf), .FDL_BIT(db),
        .FDL_VALID(dv), .RX_DATA(rxd), .RX_SLOT(rxs), .RX_VALID(rxv), .RX_READY(rxr),
        .NET_DATA(netd), .NET_SLOT(nets), .NET_VALID(netv), .NET_READY(netr),
        .LINE_TX_ENABLE(txen), .LINE_FRAMING_ESF(esf), .LINE_CODE_B8ZS(b8),
        .ALARM_EVT(evt), .LED_PORT_ON(ledon), .LED_ALARM(ledal));

    dsx1_line_model i_dsx1_line_model (.clk(clk), .line_bit(lb), .line_valid(lv),
        .fbit_valid(fv), .fbit_err(fe), .reframed(rf), .fdl_bit(db), .fdl_valid(dv),
        .rx_data(rxd), .rx_slot(rxs), .rx_valid(rxv), .rx_ready(rxr));

    task automatic finish_test;
        if (err_total == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // One bus access; request held until waitrequest is low at an edge
    task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
        int   n;
        logic s;
        n = 0;
        @(posedge clk);
        {adr, wdat, wr, rd} <= {a, d, w, ~w};
        do
        begin
            @(posedge clk);
            s = wreq;
            n++;
        end
        while (s !== 1'b0 && n < 40);
        rdat = rdo;
        {wr, rd} <= 2'b00;
        if (s !== 1'b0)
        begin
            err_total++;
            finish_test();
        end
    endtask

    task automatic rchk(input logic [3:0] a, input logic [31:0] e);
        acc(1'b0, a, 32'h0);
        `CHK(rdat, e)
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (3) @(posedge clk);
        `CHK({txen, esf, b8, ledon}, 4'b0110)
        rst_n <= 1'b1;
        rchk(dsx1_port_pkg::OFS_CTRL, 32'hfe);
        acc(1'b1, dsx1_port_pkg::OFS_XCON, 32'h8);
        rchk(dsx1_port_pkg::OFS_XCON, 32'h0);
        rchk(4'h2, 32'h0);
        acc(1'b1, dsx1_port_pkg::OFS_CTRL, 32'hff);
        acc(1'b1, dsx1_port_pkg::OFS_XCON, 32'h8);
        `CHK({txen, ledon}, 2'b11)
        i_dsx1_line_model.send_byte(5'd3, 8'h5a, ok);
        i_dsx1_line_model.send_byte(5'd4, 8'h77, ok);
        i_dsx1_line_model.send_bits(1'b0, 175);
        rchk(dsx1_port_pkg::OFS_EVT, 32'h1);
        i_dsx1_line_model.send_byte(5'd3, 8'h5a, ok);
        // Second window of all ones raises the indication alarm
        i_dsx1_line_model.send_bits(1'b1, 4096);
        rchk(dsx1_port_pkg::OFS_EVT, 32'h5);
        rchk(dsx1_port_pkg::OFS_STAT, 32'h64);
        acc(1'b1, dsx1_port_pkg::OFS_CTRL, 32'he7);
        i_dsx1_line_model.send_byte(5'd3, 8'h3c, ok);
        acc(1'b1, dsx1_port_pkg::OFS_EVT, 32'hf);
        i_dsx1_line_model.send_bits(1'b0, 175);
        rchk(dsx1_port_pkg::OFS_EVT, 32'h0);
        i_dsx1_line_model.send_fbit(1'b1);
        i_dsx1_line_model.send_fbit(1'b1);
        rchk(dsx1_port_pkg::OFS_EVT, 32'h2);
        // Stalled network side: third byte must wait, not vanish
        netr <= 1'b0;
        i_dsx1_line_model.send_byte(5'd3, 8'h11, ok);
        i_dsx1_line_model.send_byte(5'd3, 8'h22, ok);
        fork
            i_dsx1_line_model.send_byte(5'd3, 8'h33, ok);
            begin
                repeat (4) @(posedge clk);
                `CHK(rxr, 1'b0)
                netr <= 1'b1;
            end
        join
        `CHK(ok, 1'b1)
        repeat (4) @(posedge clk);
        `CHK(got.size(), 6)
        foreach (exp_q[i]) `CHK(got[i], exp_q[i])
        acc(1'b1, dsx1_port_pkg::OFS_CTRL, 32'hf9);
        acc(1'b1, dsx1_port_pkg::OFS_EVT, 32'hf);
        repeat (255) i_dsx1_line_model.send_byte(5'd5, 8'h00, ok);
        rchk(dsx1_port_pkg::OFS_EVT, 32'h8);
        `CHK({esf, b8}, 2'b00)
        acc(1'b1, dsx1_port_pkg::OFS_CTRL, 32'hfe);
        rchk(dsx1_port_pkg::OFS_XCON, 32'h0);
        `CHK({txen, ledon, ledal}, 3'b000)
        finish_test();
    end
endmodule
